// ==== verilog/wdtu_defines.svh ====
// Summary of operation
// R1: watchdog clock is sub-clock or system clock divided by four, per config option.
// R2: sub-clock comes from external 32.768 kHz crystal or internal low-speed RC.
// R3: source clock divided by power of two, 2^8 to 2^15, via bits 6..4.
// R4: control register: bit 7 keep-on, bits 6..4 timeout select, bits 3..0 enable code.
// R5: disabled only when config says disable and enable code is 1010.
// R6: power-on value: keep-on 0, timeout select 111, enable code 1010.
// R7: software should write enable code 0101 when watchdog is used.
// R8: while disabled, every watchdog instruction is a no-operation.
// R9: overflow in normal operation gives full reset and sets timeout flag.
// R10: overflow in sleep or idle sets timeout flag, resets only PC and SP.
// R11: count cleared by reset pin low, valid software clear, or halt.
// R12: config option picks single clear command or paired clear commands.
// R13: single mode: every single clear command clears the count.
// R14: paired mode: only alternating first and second commands clear the count.
// R15: divided system clock source stops in sleep or clock-off idle.
// R16: noisy systems should choose the sub-clock source.
// R17: halt with idle enable: keep-on 1 gives clock-on idle, else clock-off idle.
// R18: power-down with system clock source stops the watchdog.
// R19: timeout select code n gives divide ratio 2^(8+n).
// R20: overflow when count reaches ratio; count restarts from zero after clear.
`ifndef WDTU_DEFINES_SVH
`define WDTU_DEFINES_SVH
`define WDTU_ADDR_CONTROL 4'h0
`define WDTU_ADDR_STATUS 4'h1
`define WDTU_CTRL_RESET 8'h7a
`define WDTU_KEEPON_BIT 7
`define WDTU_TSEL_HI 6
`define WDTU_TSEL_LO 4
`define WDTU_EN_HI 3
`define WDTU_EN_LO 0
`define WDTU_EN_DISABLE 4'ha
`define WDTU_DIV_BASE_LOG2 8
`define WDTU_CNT_W 16
`define WDTU_SYS_DIV 2'h3
`define WDTU_STAT_TIMEOUT_BIT 0
`define WDTU_STAT_PDOWN_BIT 1
`endif

// ==== verilog/wdtu_pkg.sv ====
package wdtu_pkg;
    typedef enum logic [1:0] {
        WDTU_RUN,
        WDTU_SLEEP,
        WDTU_IDLE_OFF,
        WDTU_IDLE_ON
    } wdtu_pmode_e;
    typedef enum logic {
        WDTU_CLR_NONE,
        WDTU_CLR_FIRST
    } wdtu_pair_e;
endpackage

// ==== verilog/wdtu_tick_gen.sv ====
`timescale 1ns/1ps
`include "wdtu_defines.svh"
// makes the one-cycle watchdog source tick from the selected clock
module wdtu_tick_gen (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic useSubClock,
    input wire logic subClockTick,
    input wire logic sysClockRunning,
    output logic sourceTick
);
    logic [1:0] divCount;
    logic [1:0] next_divCount;
    logic next_sourceTick;

    // divided system clock simply pauses while the system clock is stopped
    always_comb begin
        next_divCount = divCount;
        next_sourceTick = 1'b0;
        if (useSubClock) begin // see R1
            next_sourceTick = subClockTick; // see R2
        end else if (sysClockRunning) begin // see R15
            next_divCount = divCount + 2'h1;
            next_sourceTick = (divCount == `WDTU_SYS_DIV); // see R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            divCount <= 2'h0;
            sourceTick <= 1'b0;
        end else begin
            divCount <= next_divCount;
            sourceTick <= next_sourceTick;
        end
    end
endmodule

// ==== verilog/wdtu_watchdog_timer_unit.sv ====
`timescale 1ns/1ps
`include "wdtu_defines.svh"
// watchdog core: control register, clear logic, counter, overflow handling
module wdtu_watchdog_timer_unit (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic cfgWdtDisable,
    input wire logic cfgUseSubClock,
    input wire logic cfgSubFromCrystal,
    input wire logic crystalTick,
    input wire logic rcTick,
    input wire logic cfgPairedClear,
    input wire logic singleClearCmd,
    input wire logic firstPairClearCmd,
    input wire logic secondPairClearCmd,
    input wire logic haltCmd,
    input wire logic idleEnableBit,
    input wire logic wakeUp,
    input wire logic externalResetPinN,
    output logic fullResetReq,
    output logic pcSpResetReq,
    output logic timeoutFlag,
    output logic powerDownFlag,
    output logic sysClockOn,
    output logic wdtEnabled
);
    logic [7:0] control;
    logic [7:0] next_control;
    wdtu_pkg::wdtu_pmode_e pmode;
    wdtu_pkg::wdtu_pmode_e next_pmode;
    wdtu_pkg::wdtu_pair_e pairState;
    wdtu_pkg::wdtu_pair_e next_pairState;
    logic [`WDTU_CNT_W-1:0] count;
    logic [`WDTU_CNT_W-1:0] next_count;
    logic next_fullResetReq;
    logic next_pcSpResetReq;
    logic next_timeoutFlag;
    logic next_powerDownFlag;
    logic next_sysClockOn;
    logic next_wdtEnabled;
    logic [7:0] next_regRdData;
    logic sourceTick;
    logic subClockTick;
    logic sysRunning;
    logic enabled;
    logic swClear;
    logic anyClear;
    logic overflow;
    logic [`WDTU_CNT_W-1:0] ratio;
    logic [2:0] tsel;

    // sub-clock oscillator choice and system clock state
    assign subClockTick = cfgSubFromCrystal ? crystalTick : rcTick; // see R2
    assign sysRunning = (pmode == wdtu_pkg::WDTU_RUN) || (pmode == wdtu_pkg::WDTU_IDLE_ON);

    wdtu_tick_gen u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .useSubClock(cfgUseSubClock),
        .subClockTick(subClockTick),
        .sysClockRunning(sysRunning), // see R18
        .sourceTick(sourceTick)
    );

    // enable decode and divide ratio
    assign enabled = !(cfgWdtDisable &&
        (control[`WDTU_EN_HI:`WDTU_EN_LO] == `WDTU_EN_DISABLE)); // see R5
    assign tsel = control[`WDTU_TSEL_HI:`WDTU_TSEL_LO]; // see R3
    assign ratio = `WDTU_CNT_W'(1) << (`WDTU_DIV_BASE_LOG2 + 32'(tsel)); // see R19

    // software clear: mode fixed by option, ignored entirely when disabled
    always_comb begin
        next_pairState = pairState;
        swClear = 1'b0;
        if (!enabled) begin
            swClear = 1'b0; // see R8
        end else if (!cfgPairedClear) begin
            swClear = singleClearCmd; // see R12 see R13
        end else begin
            // a repeated command leaves the pair state alone, so it never clears
            if (firstPairClearCmd && pairState != wdtu_pkg::WDTU_CLR_FIRST) begin
                next_pairState = wdtu_pkg::WDTU_CLR_FIRST;
                swClear = 1'b1; // see R14
            end else if (secondPairClearCmd && pairState == wdtu_pkg::WDTU_CLR_FIRST) begin
                next_pairState = wdtu_pkg::WDTU_CLR_NONE;
                swClear = 1'b1; // see R14
            end
        end
    end

    // pair tracker; rst forgets a half-done pair so a fresh first command is needed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pairState <= wdtu_pkg::WDTU_CLR_NONE;
        end else begin
            pairState <= next_pairState;
        end
    end

    assign anyClear = !externalResetPinN || swClear || (haltCmd && enabled); // see R11
    // counter reaches the top at the tick that would make it equal the ratio
    assign overflow = enabled && sourceTick && !anyClear &&
        (count == ratio - `WDTU_CNT_W'(1)); // see R20

    // counter: a clear, a disabled watchdog or an overflow restarts it from zero
    always_comb begin
        next_count = count;
        if (!enabled || anyClear) begin
            next_count = '0; // see R11 see R20
        end else if (overflow) begin
            next_count = '0; // see R20
        end else if (sourceTick) begin
            next_count = count + `WDTU_CNT_W'(1);
        end
    end

    // counter register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // overflow outcome: full reset in run mode, pc/sp reset in sleep or idle
    always_comb begin
        next_fullResetReq = 1'b0;
        next_pcSpResetReq = 1'b0;
        if (overflow) begin
            if (pmode == wdtu_pkg::WDTU_RUN) begin
                next_fullResetReq = 1'b1; // see R9
            end else begin
                next_pcSpResetReq = 1'b1; // see R10
            end
        end
    end

    // reset requests are one-cycle pulses; the reset logic stretches them as needed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fullResetReq <= 1'b0;
            pcSpResetReq <= 1'b0;
        end else begin
            fullResetReq <= next_fullResetReq;
            pcSpResetReq <= next_pcSpResetReq;
        end
    end

    // status flags: halt sets power-down and drops timeout, clear commands drop both
    always_comb begin
        next_timeoutFlag = timeoutFlag;
        next_powerDownFlag = powerDownFlag;
        if (haltCmd) begin
            next_powerDownFlag = 1'b1;
            next_timeoutFlag = 1'b0;
        end else if (swClear) begin
            next_powerDownFlag = 1'b0;
            next_timeoutFlag = 1'b0;
        end
        // a clear wins over the event in the same cycle: overflow excludes anyClear, so no timeout is set
        if (overflow) begin
            next_timeoutFlag = 1'b1; // see R9 see R10
        end
    end

    // flags survive the watchdog reset they report; of the resets, only rst clears them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            timeoutFlag <= 1'b0;
            powerDownFlag <= 1'b0;
        end else begin
            timeoutFlag <= next_timeoutFlag;
            powerDownFlag <= next_powerDownFlag;
        end
    end

    // power mode: halt picks sleep or an idle flavour; wake or overflow returns
    always_comb begin
        next_pmode = pmode;
        case (pmode)
            wdtu_pkg::WDTU_RUN: begin
                if (haltCmd && !idleEnableBit) begin
                    next_pmode = wdtu_pkg::WDTU_SLEEP;
                end else if (haltCmd && control[`WDTU_KEEPON_BIT]) begin
                    next_pmode = wdtu_pkg::WDTU_IDLE_ON; // see R17
                end else if (haltCmd) begin
                    next_pmode = wdtu_pkg::WDTU_IDLE_OFF; // see R17
                end
            end
            wdtu_pkg::WDTU_SLEEP, wdtu_pkg::WDTU_IDLE_OFF, wdtu_pkg::WDTU_IDLE_ON: begin
                if (wakeUp || overflow || !externalResetPinN) begin
                    next_pmode = wdtu_pkg::WDTU_RUN;
                end
            end
            default: begin
                next_pmode = wdtu_pkg::WDTU_RUN;
            end
        endcase
        next_sysClockOn = (next_pmode == wdtu_pkg::WDTU_RUN) ||
            (next_pmode == wdtu_pkg::WDTU_IDLE_ON);
    end

    // power mode register; the system clock flag is registered beside it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pmode <= wdtu_pkg::WDTU_RUN;
            sysClockOn <= 1'b1;
        end else begin
            pmode <= next_pmode;
            sysClockOn <= next_sysClockOn;
        end
    end

    // control write; the enable view follows the value being written, with no lag
    always_comb begin
        next_control = control;
        if (regWrite && regAddr == `WDTU_ADDR_CONTROL) begin
            next_control = regWrData; // see R4
        end
        next_wdtEnabled = !(cfgWdtDisable &&
            (next_control[`WDTU_EN_HI:`WDTU_EN_LO] == `WDTU_EN_DISABLE)); // see R5
    end

    // control register and its registered enable view
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control <= `WDTU_CTRL_RESET; // see R6
            wdtEnabled <= 1'b0;
        end else begin
            control <= next_control;
            wdtEnabled <= next_wdtEnabled;
        end
    end

    // read path: control or status, zero outside the cycle after a read strobe
    always_comb begin
        next_regRdData = 8'h00;
        if (regRead) begin
            case (regAddr)
                `WDTU_ADDR_CONTROL: next_regRdData = control;
                `WDTU_ADDR_STATUS: begin
                    next_regRdData[`WDTU_STAT_TIMEOUT_BIT] = timeoutFlag;
                    next_regRdData[`WDTU_STAT_PDOWN_BIT] = powerDownFlag;
                end
                default: next_regRdData = 8'h00;
            endcase
        end
    end

    // read data register; status is read-only, so writes to it fall away
    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_regRdData;
        end
    end
endmodule

// ==== testbench/wdtu_sva.sv ====
`timescale 1ns/1ps
// port checker for the watchdog core
module wdtu_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic cfgWdtDisable,
    input wire logic haltCmd,
    input wire logic fullResetReq,
    input wire logic pcSpResetReq,
    input wire logic timeoutFlag,
    input wire logic powerDownFlag,
    input wire logic wdtEnabled
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_full_one_cycle: assert property (fullResetReq |=> !fullResetReq)
        else $error("full reset pulse too long");
    a_pcsp_one_cycle: assert property (pcSpResetReq |=> !pcSpResetReq)
        else $error("pc/sp reset pulse too long");
    a_full_sets_flag: assert property (fullResetReq |-> ##[0:1] timeoutFlag)
        else $error("timeout flag missing after full reset");
    a_pcsp_sets_flag: assert property (pcSpResetReq |-> ##[0:1] timeoutFlag)
        else $error("timeout flag missing after pc/sp reset");
    a_disabled_quiet: assert property ((!wdtEnabled)[*2] |-> !fullResetReq && !pcSpResetReq)
        else $error("overflow while disabled");
    // enable takes the written code at the edge that samples the write; checked two edges on
    a_enable_code: assert property (regWrite && regAddr == 4'h0 |-> ##2
        wdtEnabled == ($past(regWrData[3:0], 2) != 4'ha || !cfgWdtDisable))
        else $error("enable decode wrong");
    a_read_idle_zero: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data outside its cycle");
    a_halt_pdown: assert property (haltCmd |=> powerDownFlag)
        else $error("power-down flag not set by halt");
    c_full: cover property (fullResetReq);
    c_pcsp: cover property (pcSpResetReq);
    c_halt: cover property (haltCmd);
endmodule
bind wdtu_watchdog_timer_unit wdtu_sva chk_u (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .cfgWdtDisable(cfgWdtDisable), .haltCmd(haltCmd),
    .fullResetReq(fullResetReq), .pcSpResetReq(pcSpResetReq), .timeoutFlag(timeoutFlag),
    .powerDownFlag(powerDownFlag), .wdtEnabled(wdtEnabled));

// ==== testbench/wdtu_core_model.sv ====
`timescale 1ns/1ps
// instruction decoder stand-in: opReq 1..5 gives one command pulse
module wdtu_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] opReq,
    output logic singleClearCmd,
    output logic firstPairClearCmd,
    output logic secondPairClearCmd,
    output logic haltCmd,
    output logic wakeUp
);
    logic [4:0] cmd;
    logic [4:0] next_cmd;
    // registered so pulses leave just after an edge, as a decoder would
    always_comb begin
        next_cmd = 5'h00;
        if (opReq != 3'h0) begin
            next_cmd[opReq - 3'h1] = 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        cmd <= rst ? 5'h00 : next_cmd;
    end
    assign {wakeUp, haltCmd, secondPairClearCmd, firstPairClearCmd, singleClearCmd} = cmd;
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// overflows are predicted by an integer tick model and compared as pulse counts
module tb;
    logic core_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic cfgWdtDisable = 1'b1, cfgUseSubClock = 1'b1, cfgSubFromCrystal = 1'b1;
    logic crystalTick = 1'b0, rcTick = 1'b0, cfgPairedClear = 1'b0, idleEnableBit = 1'b0;
    logic externalResetPinN = 1'b1;
    logic [2:0] opReq = 3'h0;
    logic sClr, fClr, pClr, haltCmd, wakeUp;
    logic fullResetReq, pcSpResetReq, timeoutFlag, powerDownFlag, sysClockOn, wdtEnabled;
    int nErrors = 0, testsRun = 0, nSeen = 0, nPcSp = 0, nExp = 0, mcnt = 0, th = 256;
    bit en = 1'b0;
    logic [15:0] rnd = 16'he757;
    always #25 core_clk = ~core_clk;
    wdtu_core_model core_u (.core_clk(core_clk), .rst(rst), .opReq(opReq),
        .singleClearCmd(sClr), .firstPairClearCmd(fClr), .secondPairClearCmd(pClr),
        .haltCmd(haltCmd), .wakeUp(wakeUp));
    wdtu_watchdog_timer_unit dut_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .cfgWdtDisable(cfgWdtDisable), .cfgUseSubClock(cfgUseSubClock),
        .cfgSubFromCrystal(cfgSubFromCrystal), .crystalTick(crystalTick), .rcTick(rcTick),
        .cfgPairedClear(cfgPairedClear), .singleClearCmd(sClr), .firstPairClearCmd(fClr),
        .secondPairClearCmd(pClr), .haltCmd(haltCmd), .idleEnableBit(idleEnableBit),
        .wakeUp(wakeUp), .externalResetPinN(externalResetPinN), .fullResetReq(fullResetReq),
        .pcSpResetReq(pcSpResetReq), .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
        .sysClockOn(sysClockOn), .wdtEnabled(wdtEnabled));
    // pulse counter; the pulses are registered, so the edge sees them settled
    always @(posedge core_clk) begin
        if (fullResetReq === 1'b1 || pcSpResetReq === 1'b1) nSeen++;
        if (pcSpResetReq === 1'b1) nPcSp++;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (nErrors == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        // data stand for one cycle; take them at the edge that ends it
        @(posedge core_clk);
        d = regRdData;
    endtask
    task automatic op(input logic [2:0] c);
        @(posedge core_clk);
        opReq <= c;
        @(posedge core_clk);
        opReq <= 3'h0;
        repeat (2) @(posedge core_clk);
    endtask
    // n sub-clock ticks at random spacing, mirrored by the model count
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge core_clk);
            crystalTick <= cfgSubFromCrystal;
            rcTick <= !cfgSubFromCrystal;
            @(posedge core_clk);
            crystalTick <= 1'b0;
            rcTick <= 1'b0;
            rnd = lfsr(rnd);
            if (rnd[0]) @(posedge core_clk);
            if (en) mcnt++;
            if (mcnt == th) begin
                nExp++;
                mcnt = 0;
            end
        end
        repeat (4) @(posedge core_clk);
        chk(nSeen, nExp);
    endtask
    initial begin
        logic [7:0] d;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd(4'h0, d);
        chk(d, 8'h7a);
        rd(4'h9, d);
        chk(d, 8'h00);
        chk(wdtEnabled, 1'b0);
        op(3'h1);
        tk(300);
        wr(4'h0, 8'h05);
        rd(4'h0, d);
        chk(d, 8'h05);
        chk(wdtEnabled, 1'b1);
        en = 1'b1;
        // timeout codes 0 to 2: a clear keeps it quiet, then one overflow at the ratio
        for (int k = 0; k < 3; k++) begin
            cfgSubFromCrystal <= k[0];
            th = 256 << k;
            wr(4'h0, {1'b0, k[2:0], 4'h5});
            op(3'h1);
            mcnt = 0;
            tk(th - 60);
            op(3'h1);
            mcnt = 0;
            tk(th - 60);
            tk(120);
            chk(timeoutFlag, 1'b1);
        end
        rd(4'h1, d);
        chk(d & 8'h01, 8'h01);
        wr(4'h0, 8'h05);
        th = 256;
        cfgPairedClear <= 1'b1;
        op(3'h2);
        mcnt = 0;
        chk(timeoutFlag, 1'b0);
        tk(200);
        op(3'h2);
        tk(100);
        op(3'h3);
        mcnt = 0;
        tk(200);
        op(3'h3);
        tk(100);
        op(3'h2);
        mcnt = 0;
        tk(200);
        cfgPairedClear <= 1'b0;
        tk(100);
        externalResetPinN <= 1'b0;
        repeat (2) @(posedge core_clk);
        externalResetPinN <= 1'b1;
        mcnt = 0;
        tk(200);
        wr(4'h0, 8'h85);
        idleEnableBit <= 1'b1;
        op(3'h4);
        mcnt = 0;
        chk(sysClockOn, 1'b1);
        tk(300);
        chk(nPcSp, 16'h0001);
        rd(4'h1, d);
        chk(d, 8'h03);
        op(3'h5);
        wr(4'h0, 8'h05);
        op(3'h4);
        chk(sysClockOn, 1'b0);
        op(3'h5);
        chk(sysClockOn, 1'b1);
        cfgUseSubClock <= 1'b0;
        idleEnableBit <= 1'b0;
        op(3'h1);
        op(3'h4);
        repeat (1500) @(posedge core_clk);
        chk(nSeen, nExp);
        op(3'h5);
        op(3'h1);
        repeat (900) @(posedge core_clk);
        chk(nSeen, nExp);
        repeat (250) @(posedge core_clk);
        chk(nSeen, nExp + 1);
        cfgWdtDisable <= 1'b0;
        wr(4'h0, 8'h7a);
        @(posedge core_clk);
        chk(wdtEnabled, 1'b1);
        tally_and_finish;
    end
    // hang guard, far above the normal run length
    initial begin
        repeat (60000) @(posedge core_clk);
        nErrors++;
        tally_and_finish;
    end
endmodule
